/* shared/spi_fe_pkg.sv */
// package for the serial memory pin front end: pin carrier, states, counts
// assumes one core clock that oversamples every pin at least 8x the serial clock
package spi_fe_pkg;

    // =====================================================================
    // counts
    localparam int unsigned BYTE_BITS = 8;
    localparam int unsigned CNT_W     = 3;
    localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
    localparam logic [CNT_W-1:0] CNT_ONE  = 3'h1;
    localparam logic [CNT_W-1:0] CNT_LAST = 3'h7;
    localparam logic [BYTE_BITS-1:0] BYTE_ZERO = 8'h00;
    localparam int unsigned MSB = BYTE_BITS - 1;

    // =====================================================================
    // types
    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic hold_n;
        logic wp_n;
    } pin_t;

    localparam pin_t PIN_IDLE = 5'h13; // deselected, clock low, pause and protect high

    typedef struct packed {
        logic                 first;  // first byte since select
        logic [BYTE_BITS-1:0] data;
    } rx_word_t;

    localparam rx_word_t RX_ZERO = 9'h000;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_ACTIVE = 3'b010,
        ST_PAUSED = 3'b100
    } port_state_t;

    // =====================================================================
    function automatic logic rose(input logic cur, input logic prev);
        return cur & ~prev;
    endfunction : rose

    function automatic logic fell(input logic cur, input logic prev);
        return ~cur & prev;
    endfunction : fell

endpackage : spi_fe_pkg

/* hdl/pair_buffer.sv */
// two-entry valid/ready buffer for received bytes
// assumes both sides on core_clk; outputs come from registers
`timescale 1ns/1ps
module pair_buffer
    import spi_fe_pkg::*;
(
    input  wire logic     core_clk,  // core clock
    input  wire logic     srst,      // sync reset, high
    input  wire logic     in_valid,  // word offered
    output logic          in_ready,  // room for a word
    input  wire rx_word_t in_word,   // word in
    output logic          out_valid, // word held
    input  wire logic     out_ready, // drain accepts
    output rx_word_t      out_word   // word out
);

    // =====================================================================
    // head entry drives the outputs, spare entry absorbs one stall
    rx_word_t head_reg, head_next, spare_reg, spare_next;
    logic     hv_reg, hv_next, sv_reg, sv_next;

    always_comb begin
        head_next  = head_reg;
        spare_next = spare_reg;
        hv_next    = hv_reg;
        sv_next    = sv_reg;
        if (hv_reg && out_ready) begin
            hv_next   = sv_reg;
            head_next = spare_reg;
            sv_next   = 1'b0;
        end
        if (in_valid && !sv_reg) begin
            if (!hv_next) begin
                hv_next   = 1'b1;
                head_next = in_word;
            end else begin
                sv_next    = 1'b1;
                spare_next = in_word;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            head_reg  <= RX_ZERO;
            spare_reg <= RX_ZERO;
            hv_reg    <= 1'b0;
            sv_reg    <= 1'b0;
        end else begin
            head_reg  <= head_next;
            spare_reg <= spare_next;
            hv_reg    <= hv_next;
            sv_reg    <= sv_next;
        end
    end

    assign in_ready  = !sv_reg;
    assign out_valid = hv_reg;
    assign out_word  = head_reg;

endmodule : pair_buffer

/* hdl/spi_pin_front_end.sv */
// pin front end of a serial memory slave port: shifting, pause, protect gating
// assumes pins arrive asynchronously and core_clk is at least 8x the serial clock;
// sequence kind flags come from an instruction decoder on core_clk
`timescale 1ns/1ps
module spi_pin_front_end
    import spi_fe_pkg::*;
(
    input  wire logic                 core_clk,               // 25 MHz core clock
    input  wire logic                 srst,                   // sync reset, high
    input  wire logic                 cs_n,                   // chip select pin, low
    input  wire logic                 sck,                    // serial clock pin
    input  wire logic                 si,                     // serial data in pin
    input  wire logic                 hold_n,                 // pause pin, low
    input  wire logic                 wp_n,                   // protect pin, low
    output logic                      so_out,                 // serial out level
    output logic                      so_oe,                  // serial out drive enable
    input  wire logic                 protect_pin_enable_bit, // status enable bit
    input  wire logic                 sr_write_seq,           // open sequence writes status
    input  wire logic                 write_seq,              // open sequence is other write
    input  wire logic [BYTE_BITS-1:0] tx_data,                // next byte to send
    output logic                      tx_load,                // tx_data taken
    output logic                      rx_valid,               // byte available
    input  wire logic                 rx_ready,               // byte consumed
    output rx_word_t                  rx_word,                // received byte
    output logic                      rx_overrun,             // byte lost since select
    output logic                      sr_commit,              // status write launched
    output logic                      sr_refused,             // status write discarded
    output logic                      write_start,            // write cycle launched
    output logic                      selected,               // port selected
    output logic                      paused                  // port paused
);

    // =====================================================================
    // pin synchronisers; only the second stage and later are read
    pin_t meta_reg, pins_s;
    logic sck_d, cs_d, wp_d, hold_d;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            meta_reg <= PIN_IDLE;
            pins_s   <= PIN_IDLE;
            sck_d    <= 1'b0;
            cs_d     <= 1'b1;
            wp_d     <= 1'b1;
            hold_d   <= 1'b1;
        end else begin
            meta_reg <= '{cs_n: cs_n, sck: sck, si: si, hold_n: hold_n, wp_n: wp_n};
            pins_s   <= meta_reg;
            sck_d    <= pins_s.sck;
            cs_d     <= pins_s.cs_n;
            wp_d     <= pins_s.wp_n;
            hold_d   <= pins_s.hold_n;
        end
    end

    logic sck_rise, sck_fall, cs_rise, cs_fall, hold_rise;
    assign hold_rise = rose(pins_s.hold_n, hold_d);
    assign sck_rise = rose(pins_s.sck, sck_d);
    assign sck_fall = fell(pins_s.sck, sck_d);
    assign cs_rise  = rose(pins_s.cs_n, cs_d);
    assign cs_fall  = fell(pins_s.cs_n, cs_d);

    // =====================================================================
    // port state and shifters
    port_state_t          state_reg, state_next;
    logic [CNT_W-1:0]     cnt_reg, cnt_next;
    logic [BYTE_BITS-1:0] rx_sh_reg, rx_sh_next, tx_sh_reg, tx_sh_next;
    logic                 first_reg, first_next, ovr_reg, ovr_next;
    logic                 so_reg, so_next, oe_reg, oe_next, load_reg, load_next;
    logic                 push;
    rx_word_t             push_word;
    logic                 buf_ready;
    logic                 live;
    logic                 sel_reg, sel_next, pause_reg, pause_next;

    // edges count only in the active state, never while paused
    assign live = (state_reg == ST_ACTIVE);

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        rx_sh_next = rx_sh_reg;
        tx_sh_next = tx_sh_reg;
        first_next = first_reg;
        ovr_next   = ovr_reg;
        so_next    = so_reg;
        load_next  = 1'b0;
        push       = 1'b0;
        push_word  = RX_ZERO;
        unique case (state_reg)
            ST_IDLE: begin
                if (cs_fall) begin
                    state_next = ST_ACTIVE;
                    cnt_next   = CNT_ZERO;
                    first_next = 1'b1;
                    ovr_next   = 1'b0;
                    so_next    = tx_data[MSB];
                    tx_sh_next = {tx_data[MSB-1:0], 1'b0};
                    load_next  = 1'b1;
                end
            end
            ST_ACTIVE: begin
                // pause only with the clock low; a request made high waits for the fall
                if (!pins_s.hold_n && !pins_s.sck) begin
                    state_next = ST_PAUSED;
                end
            end
            ST_PAUSED: begin
                // only a release edge made with the clock low resumes; one made high is lost
                if (hold_rise && !pins_s.sck) begin
                    state_next = ST_ACTIVE;
                end
            end
        endcase
        if (live && sck_rise) begin
            rx_sh_next = {rx_sh_reg[MSB-1:0], pins_s.si};
            cnt_next   = cnt_reg + CNT_ONE;
            if (cnt_reg == CNT_LAST) begin
                push       = 1'b1;
                push_word  = '{first: first_reg, data: {rx_sh_reg[MSB-1:0], pins_s.si}};
                first_next = 1'b0;
                ovr_next   = ovr_reg | ~buf_ready;
            end
        end
        if (live && sck_fall) begin
            if (cnt_reg == CNT_ZERO) begin
                so_next    = tx_data[MSB];
                tx_sh_next = {tx_data[MSB-1:0], 1'b0};
                load_next  = 1'b1;
            end else begin
                so_next    = tx_sh_reg[MSB];
                tx_sh_next = {tx_sh_reg[MSB-1:0], 1'b0};
            end
        end
        // deselect wins over everything, including a pause in progress
        if (pins_s.cs_n) begin
            state_next = ST_IDLE;
        end
        // released while paused, deselected or while the pause pin is low
        oe_next = (state_next == ST_ACTIVE) && pins_s.hold_n;
        sel_next   = (state_next != ST_IDLE);
        pause_next = (state_next == ST_PAUSED);
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= CNT_ZERO;
            rx_sh_reg <= BYTE_ZERO;
            tx_sh_reg <= BYTE_ZERO;
            first_reg <= 1'b0;
            ovr_reg   <= 1'b0;
            so_reg    <= 1'b0;
            oe_reg    <= 1'b0;
            load_reg  <= 1'b0;
            sel_reg   <= 1'b0;
            pause_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            rx_sh_reg <= rx_sh_next;
            tx_sh_reg <= tx_sh_next;
            first_reg <= first_next;
            ovr_reg   <= ovr_next;
            so_reg    <= so_next;
            oe_reg    <= oe_next;
            load_reg  <= load_next;
            sel_reg   <= sel_next;
            pause_reg <= pause_next;
        end
    end

    // =====================================================================
    // commit of the closing sequence; protect pin judged only here, so a later
    // fall cannot reach a cycle that has already launched
    logic commit_reg, commit_next, refuse_reg, refuse_next, wstart_reg, wstart_next;
    logic guarded;

    assign guarded = protect_pin_enable_bit && !pins_s.wp_n;

    always_comb begin
        commit_next = 1'b0;
        refuse_next = 1'b0;
        wstart_next = 1'b0;
        if (cs_rise && state_reg != ST_IDLE) begin
            if (sr_write_seq) begin
                commit_next = !guarded;
                refuse_next = guarded;
            end
            wstart_next = write_seq;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            commit_reg <= 1'b0;
            refuse_reg <= 1'b0;
            wstart_reg <= 1'b0;
        end else begin
            commit_reg <= commit_next;
            refuse_reg <= refuse_next;
            wstart_reg <= wstart_next;
        end
    end

    // =====================================================================
    // received bytes; the spare entry covers a one-byte stall by the reader
    pair_buffer u_rx_buf (
        .core_clk  (core_clk),
        .srst      (srst),
        .in_valid  (push),
        .in_ready  (buf_ready),
        .in_word   (push_word),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_word  (rx_word)
    );

    assign so_out      = so_reg;
    assign so_oe       = oe_reg;
    assign tx_load     = load_reg;
    assign rx_overrun  = ovr_reg;
    assign sr_commit   = commit_reg;
    assign sr_refused  = refuse_reg;
    assign write_start = wstart_reg;
    assign selected    = sel_reg;
    assign paused      = pause_reg;

    // =====================================================================
    // checks
    sequence s_close_sr;
        cs_rise && state_reg != ST_IDLE && sr_write_seq;
    endsequence

    sequence s_hold_with_clk_high;
        live && !pins_s.hold_n && pins_s.sck && !pins_s.cs_n;
    endsequence

    a_so_hiz_hold: assert property (@(posedge core_clk) disable iff (srst)
        !pins_s.hold_n |=> !so_oe)
        else $error("serial out driven with pause low");
    a_so_hiz_desel: assert property (@(posedge core_clk) disable iff (srst)
        pins_s.cs_n |=> !so_oe && !selected)
        else $error("serial out driven while deselected");
    a_sr_wp_refuse: assert property (@(posedge core_clk) disable iff (srst)
        s_close_sr and (protect_pin_enable_bit && !pins_s.wp_n)
        |=> sr_refused && !sr_commit)
        else $error("protected status write not refused");
    a_sr_wp_high: assert property (@(posedge core_clk) disable iff (srst)
        s_close_sr and pins_s.wp_n |=> sr_commit && !sr_refused)
        else $error("status write refused with protect pin high");
    a_sr_en_zero: assert property (@(posedge core_clk) disable iff (srst)
        s_close_sr and !protect_pin_enable_bit |=> sr_commit)
        else $error("status write refused with enable bit clear");
    a_sr_judge_commit: assert property (@(posedge core_clk) disable iff (srst)
        sr_commit || sr_refused |-> $past(cs_rise) && $past(sr_write_seq))
        else $error("status write judged outside a commit");
    a_wp_no_abort: assert property (@(posedge core_clk) disable iff (srst)
        fell(pins_s.wp_n, wp_d) && !cs_rise |=> !sr_refused)
        else $error("protect pin fall acted outside a commit");
    a_write_launch: assert property (@(posedge core_clk) disable iff (srst)
        cs_rise && state_reg != ST_IDLE && write_seq |=> write_start)
        else $error("write cycle not launched at deselect");
    a_capture_rise: assert property (@(posedge core_clk) disable iff (srst)
        live && sck_rise && !pins_s.cs_n |=> cnt_reg == $past(cnt_reg) + CNT_ONE)
        else $error("bit not captured on clock rise");
    a_so_after_fall: assert property (@(posedge core_clk) disable iff (srst)
        $changed(so_out) |-> $past(sck_fall) || $past(cs_fall))
        else $error("serial out changed without a clock fall");
    a_pause_freeze: assert property (@(posedge core_clk) disable iff (srst)
        paused && !pins_s.cs_n |=> $stable(cnt_reg) && $stable(rx_sh_reg)
        && $stable(tx_sh_reg))
        else $error("shift state moved while paused");
    a_pause_defer: assert property (@(posedge core_clk) disable iff (srst)
        s_hold_with_clk_high |=> !paused)
        else $error("pause entered with clock high");
    a_resume_low: assert property (@(posedge core_clk) disable iff (srst)
        paused && pins_s.hold_n && pins_s.sck && !pins_s.cs_n |=> paused)
        else $error("resumed with clock high");

endmodule : spi_pin_front_end

/* test/spi_master_model.sv */
// bus master model: drives select, serial clock, data, pause and protect pins
// assumes callers allow for the pin synchronisers; serial clock period 320 ns
`timescale 1ns/1ps
module spi_master_model (
    output logic     cs_n,   // chip select, low
    output logic     sck,    // serial clock
    output logic     si,     // data to device
    output logic     hold_n, // pause, low
    output logic     wp_n,   // protect, low
    input wire logic so_out, // device data
    input wire logic so_oe   // device drives data
);
    localparam int HALF = 160;

    logic last_so;

    // =====================================================================
    // pins
    initial begin
        cs_n    = 1'b1;
        sck     = 1'b0;
        si      = 1'b0;
        hold_n  = 1'b1;
        wp_n    = 1'b1;
        last_so = 1'b0;
    end

    // a released output reads as the inverse of its last bit, never a lucky match
    task automatic rise(input logic b, output logic r);
        si = b;
        #HALF;
        sck = 1'b1;
        r = so_oe ? so_out : ~last_so;
        last_so = r;
    endtask : rise

    task automatic fall();
        #HALF;
        sck = 1'b0;
    endtask : fall

    task automatic byte_io(input logic [7:0] b, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            rise(b[i], r[i]);
            fall();
        end
    endtask : byte_io

    // clock rests low outside frames; select stays low through any pause
    task automatic select();
        #13;
        cs_n = 1'b0;
        #200;
    endtask : select

    task automatic deselect();
        #HALF;
        cs_n = 1'b1;
        si   = ~si;
        #200;
    endtask : deselect

    task automatic set_hold(input logic v);
        hold_n = v;
    endtask : set_hold

    task automatic set_wp(input logic v);
        wp_n = v;
    endtask : set_wp
endmodule : spi_master_model

/* test/spi_pin_front_end_hold_wp_test.sv */
// self-checking bench for the serial port pin front end
// assumes the master model drives all pins; core-side inputs change on clock edges
`timescale 1ns/1ps
`define CHECK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin fail_count++; \
    $display("[FAIL] %s expected %h seen %h", what, exp, got); end end
module spi_pin_front_end_hold_wp_test;
    import spi_fe_pkg::*;

    logic           core_clk, srst, protect_pin_enable_bit, sr_write_seq, write_seq, rx_ready;
    logic [7:0]     tx_data;
    logic           cs_n, sck, si, hold_n, wp_n, so_out, so_oe, tx_load, rx_valid, rx_overrun;
    logic           sr_commit, sr_refused, write_start, selected, paused;
    rx_word_t       rx_word;
    logic           got_commit, got_refuse, got_start, got_load;
    int             fail_count = 0;
    int             n_tests = 0;

    spi_master_model m (.cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n),
                        .so_out(so_out), .so_oe(so_oe));
    spi_pin_front_end uut (.core_clk(core_clk), .srst(srst), .cs_n(cs_n), .sck(sck), .si(si),
        .hold_n(hold_n), .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe),
        .protect_pin_enable_bit(protect_pin_enable_bit), .sr_write_seq(sr_write_seq),
        .write_seq(write_seq), .tx_data(tx_data), .tx_load(tx_load), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_word(rx_word), .rx_overrun(rx_overrun), .sr_commit(sr_commit),
        .sr_refused(sr_refused), .write_start(write_start), .selected(selected),
        .paused(paused));

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // pulses last one cycle, so they are collected as they pass
    always @(posedge core_clk) begin
        if (sr_commit === 1'b1) got_commit = 1'b1;
        if (sr_refused === 1'b1) got_refuse = 1'b1;
        if (write_start === 1'b1) got_start = 1'b1;
        if (tx_load === 1'b1) got_load = 1'b1;
    end

    // =====================================================================
    // helpers
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    task automatic pop(input rx_word_t exp);
        int k;
        #1;
        for (k = 0; k < 40 && rx_valid !== 1'b1; k++) @(posedge core_clk) #1;
        if (k == 40) begin
            fail_count++;
            $display("[FAIL] rx_valid expected 1 seen %b", rx_valid);
            end_of_test();
        end
        `CHECK("rx_word", exp, rx_word)
        @(posedge core_clk) rx_ready <= 1'b1;
        @(posedge core_clk) rx_ready <= 1'b0;
    endtask : pop

    // one whole selection: byte in, byte out, commit pulses collected
    task automatic frame(input logic [7:0] b);
        logic [7:0] r;
        got_commit = 1'b0;
        got_refuse = 1'b0;
        got_start  = 1'b0;
        got_load   = 1'b0;
        m.select();
        `CHECK("selected", 1'b1, selected)
        m.byte_io(b, r);
        `CHECK("serial out byte", tx_data, r)
        m.deselect();
        `CHECK("so_oe deselected", 1'b0, so_oe)
        `CHECK("selected", 1'b0, selected)
        `CHECK("tx_load seen", 1'b1, got_load)
        pop({1'b1, b});
    endtask : frame

    // =====================================================================
    // scenarios
    task automatic protect_test();
        logic [1:0] c;
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            @(posedge core_clk);
            protect_pin_enable_bit <= c[1];
            sr_write_seq           <= 1'b1;
            m.set_wp(c[0]);
            frame(8'h01);
            `CHECK("sr_refused", c[1] & ~c[0], got_refuse)
            `CHECK("sr_commit", ~(c[1] & ~c[0]), got_commit)
        end
        // protect fall after the cycle has launched must not undo it
        m.set_wp(1'b0);
        repeat (10) @(posedge core_clk);
        `CHECK("late protect refusal", 1'b0, got_refuse)
        @(posedge core_clk);
        sr_write_seq <= 1'b0;
        write_seq    <= 1'b1;
        frame(8'h02);
        `CHECK("write_start", 1'b1, got_start)
        `CHECK("no refusal", 1'b0, got_refuse)
        write_seq <= 1'b0;
        $display("protect test done");
    endtask : protect_test

    task automatic overrun_test();
        logic [7:0] r;
        m.select();
        m.byte_io(8'h11, r);
        m.byte_io(8'h22, r);
        m.byte_io(8'h33, r);
        m.deselect();
        `CHECK("rx_overrun", 1'b1, rx_overrun)
        pop({1'b1, 8'h11});
        pop({1'b0, 8'h22});
        repeat (2) @(posedge core_clk);
        `CHECK("rx_valid drained", 1'b0, rx_valid)
        $display("overrun test done");
    endtask : overrun_test

    task automatic pause_test();
        logic [7:0] pb;
        logic [7:0] r;
        logic       d;
        pb = 8'h96;
        m.select();
        `CHECK("rx_overrun cleared", 1'b0, rx_overrun)
        for (int i = 7; i >= 4; i--) begin
            m.rise(pb[i], r[i]);
            m.fall();
        end
        m.rise(pb[3], r[3]);
        m.set_hold(1'b0);
        #120;
        `CHECK("paused with clock high", 1'b0, paused)
        m.fall();
        #160;
        `CHECK("paused", 1'b1, paused)
        `CHECK("so_oe paused", 1'b0, so_oe)
        repeat (2) begin
            m.rise(~pb[2], d);
            m.fall();
        end
        `CHECK("so_oe after noise", 1'b0, so_oe)
        m.rise(1'b0, d);
        m.set_hold(1'b1);
        #160;
        `CHECK("release with clock high", 1'b1, paused)
        m.fall();
        #160;
        `CHECK("late release ignored", 1'b1, paused)
        m.set_hold(1'b0);
        #160;
        m.set_hold(1'b1);
        #160;
        `CHECK("resumed", 1'b0, paused)
        for (int i = 2; i >= 0; i--) begin
            m.rise(pb[i], r[i]);
            m.fall();
        end
        m.deselect();
        `CHECK("serial out across pause", tx_data, r)
        pop({1'b1, pb});
        $display("pause test done");
    endtask : pause_test

    // =====================================================================
    // main sequence
    initial begin
        srst                   = 1'b1;
        protect_pin_enable_bit = 1'b0;
        sr_write_seq           = 1'b0;
        write_seq              = 1'b0;
        rx_ready               = 1'b0;
        tx_data                = 8'h3c;
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
        `CHECK("so_oe after reset", 1'b0, so_oe)
        frame(8'h5a);
        $display("basic test done");
        protect_test();
        overrun_test();
        pause_test();
        end_of_test();
    end
endmodule : spi_pin_front_end_hold_wp_test
